// File: ifp_pkg.sv
// shared constants, encodings and carrier types for the fetch pipeline
// assumes a 20 MHz core clock and a word-wide program memory port
package ifp_pkg;

  // ************************************************************
  // widths and reset values
  // ************************************************************
  localparam int          PC_W       = 21;
  localparam int          WORD_W     = 16;
  localparam int          DADDR_W    = 12;
  localparam int          BYTE_W     = 8;
  localparam int          PTRSEL_W   = 2;
  localparam logic [20:0] PC_RESET   = 21'h000000;
  localparam logic [20:0] PC_STEP    = 21'h000002;  // one instruction word is two bytes
  localparam logic [7:0]  WORKING_REGISTER_RESET = 8'h00;
  localparam logic [3:0]  PHASE_OH_RESET = 4'h1;

  // ************************************************************
  // instruction field positions and opcode patterns
  // ************************************************************
  localparam int          ACC_BIT       = 8;         // 'a' bank select bit
  localparam int          DST_BIT       = 9;         // 'd' destination bit
  localparam logic [3:0]  SECOND_TAG    = 4'hf;      // top nibble of a second word
  localparam logic [7:0]  GOTO_HI       = 8'hef;
  localparam logic [6:0]  CALL_HI       = 7'h76;
  localparam logic [7:0]  PTRLOAD_HI    = 8'hee;
  localparam logic [3:0]  FFMOVE_HI     = 4'hc;
  localparam logic [4:0]  BRA_HI        = 5'h1a;
  localparam logic [5:0]  ADD_WORKING_TO_FILE_HI      = 6'h09;
  localparam logic [6:0]  TEST_SKIP_IF_ZERO_HI     = 7'h33;
  localparam logic [7:0]  MOVLW_HI      = 8'h0e;
  localparam logic [7:0]  RETURN_WITH_LITERAL_HI      = 8'h0c;
  localparam logic [15:0] TBLRD_OP      = 16'h0008;
  localparam logic [15:0] TBLRD_INC_OP  = 16'h0009;

  // ************************************************************
  // data memory map seen by the core
  // ************************************************************
  localparam logic [7:0]  ACC_SPLIT       = 8'h80;   // access bank: low half GPR, high half SFR
  localparam logic [3:0]  BANK_GPR        = 4'h0;
  localparam logic [3:0]  BANK_SFR        = 4'hf;
  localparam logic [11:0] ADDR_CNT_LOW    = 12'hff9;
  localparam logic [11:0] ADDR_TBL_LATCH  = 12'hff5;
  localparam logic [11:0] ADDR_TBL_PTR_L  = 12'hff6;
  localparam logic [11:0] ADDR_TBL_PTR_H  = 12'hff7;
  localparam logic [11:0] ADDR_TBL_PTR_U  = 12'hff8;

  // ************************************************************
  // types
  // ************************************************************
  // gray sequence around the instruction cycle
  typedef enum logic [1:0] {
    PH_ONE   = 2'b00,
    PH_TWO   = 2'b01,
    PH_THREE = 2'b11,
    PH_FOUR  = 2'b10
  } ifp_phase_e;

  typedef enum logic [3:0] {
    OP_NOP, OP_SECOND, OP_GOTO, OP_CALL, OP_FFMOVE, OP_PTRLOAD, OP_BRA,
    OP_ADD_WORKING_TO_FILE, OP_TEST_SKIP_IF_ZERO, OP_MOVLW, OP_RETURN_WITH_LITERAL, OP_TBLRD, OP_TBLRD_INC
  } ifp_op_e;

  typedef struct packed {
    logic                rd;
    logic                wr;
    logic [DADDR_W-1:0]  addr;
    logic [BYTE_W-1:0]   wdata;
  } ifp_dmem_s;

  typedef struct packed {
    logic             push;
    logic             pop;
    logic [PC_W-1:0]  addr;
  } ifp_ret_s;

  typedef struct packed {
    logic                load;
    logic [PTRSEL_W-1:0] index;
    logic [DADDR_W-1:0]  value;
  } ifp_ptr_s;

endpackage

// File: ifp_phase_gen.sv
// four-phase sequencer that splits the core clock into instruction cycles
// assumes a synchronised active-low reset from the enclosing core
`timescale 1ns/1ps

module ifp_phase_gen
  import ifp_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_ni,
  output ifp_phase_e      phase_o,
  output logic [3:0]      phase_oh_o
);

  ifp_phase_e phase_d;

  // ************************************************************
  // divide by four
  // ************************************************************
  // gray order keeps one bit changing per step
  always_comb begin
    unique case (phase_o)
      PH_ONE:   phase_d = PH_TWO;
      PH_TWO:   phase_d = PH_THREE;
      PH_THREE: phase_d = PH_FOUR;
      PH_FOUR:  phase_d = PH_ONE;
    endcase
  end

  // phase register and its one-hot copy for the pins
  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      phase_o    <= PH_ONE;
      phase_oh_o <= PHASE_OH_RESET;
    end else begin
      phase_o    <= phase_d;                        // RULE_01
      phase_oh_o <= {phase_oh_o[2:0], phase_oh_o[3]}; // RULE_01
    end
  end

endmodule

// File: ifp_fetch_core.sv
// instruction fetch and pipeline sequencing of an 8-bit core
// assumes word-wide program memory answering within phases two to four,
// an outside return stack, and byte data memory answering within phase two
`timescale 1ns/1ps

// How it works
// RULE_01: clock divided by four into phase_one..phase_four, one instruction cycle.
// RULE_02: program_counter steps in phase_one; fetched word captured in phase_four.
// RULE_03: fetch of next word overlaps decode and execute of current one.
// RULE_04: any change of flow takes two cycles; prefetched word is discarded.
// RULE_05: instruction_latch loads in phase_one; execution spans phases two to four.
// RULE_06: operand read in phase_two; destination written in phase_four.
// RULE_07: program memory byte addressed; words start at even addresses.
// RULE_08: program_counter steps by two; its bit zero always reads zero.
// RULE_09: absolute jump and call load a word address into counter bits 20..1.
// RULE_10: branch offset counts words, so it is doubled before adding.
// RULE_11: four two-word instructions: call, jump, file_to_file_move, pointer_load_literal.
// RULE_12: second words carry 1111 on top and twelve bits of literal.
// RULE_13: a lone second word is a no-op; right after its first it is consumed.
// RULE_14: add_working_to_file into counter_low_byte redirects fetch, a computed jump.
// RULE_15: software keeps the computed-jump offset even so targets stay aligned.
// RULE_16: return_with_literal returns and leaves its byte in working_register.
// RULE_17: table reads use a byte pointer and a one-byte data latch.
module ifp_fetch_core
  import ifp_pkg::*;
(
  input  wire logic              CLK_I,
  input  wire logic              NRST_I,
  input  wire logic [WORD_W-1:0] PMEM_DATA_I,
  input  wire logic [BYTE_W-1:0] DMEM_RDATA_I,
  input  wire logic [3:0]        BANK_I,
  input  wire logic [PC_W-1:0]   RET_ADDR_I,
  input  wire logic [BYTE_W-1:0] TBL_DATA_I,
  output logic [3:0]             PHASE_O,
  output logic [PC_W-1:0]        PMEM_ADDR_O,
  output logic                   PMEM_RD_O,
  output ifp_dmem_s              DMEM_O,
  output logic [PC_W-1:0]        TBL_ADDR_O,
  output logic                   TBL_RD_O,
  output ifp_ret_s               RET_O,
  output ifp_ptr_s               PTR_LOAD_O,
  output logic [WORD_W-1:0]      EXEC_WORD_O,
  output logic                   EXEC_VALID_O,
  output logic [BYTE_W-1:0]      WORKING_REGISTER_O
);

  // ************************************************************
  // decode helpers
  // ************************************************************
  // raw opcode class of one word
  function automatic ifp_op_e dec_f(input logic [WORD_W-1:0] w);
    ifp_op_e o;
    o = OP_NOP;
    if (w[15:12] == SECOND_TAG) o = OP_SECOND;             // RULE_12
    else if (w[15:8] == GOTO_HI) o = OP_GOTO;              // RULE_11
    else if (w[15:9] == CALL_HI) o = OP_CALL;              // RULE_11
    else if (w[15:8] == PTRLOAD_HI) o = OP_PTRLOAD;        // RULE_11
    else if (w[15:12] == FFMOVE_HI) o = OP_FFMOVE;         // RULE_11
    else if (w[15:11] == BRA_HI) o = OP_BRA;
    else if (w[15:10] == ADD_WORKING_TO_FILE_HI) o = OP_ADD_WORKING_TO_FILE;
    else if (w[15:9] == TEST_SKIP_IF_ZERO_HI) o = OP_TEST_SKIP_IF_ZERO;
    else if (w[15:8] == MOVLW_HI) o = OP_MOVLW;
    else if (w[15:8] == RETURN_WITH_LITERAL_HI) o = OP_RETURN_WITH_LITERAL;
    else if (w == TBLRD_OP) o = OP_TBLRD;
    else if (w == TBLRD_INC_OP) o = OP_TBLRD_INC;
    return o;
  endfunction

  // what the latched word does this cycle, given its pairing state
  function automatic ifp_op_e xop_f(input logic ok, input logic pend,
                                    input logic [WORD_W-1:0] w, input logic [WORD_W-1:0] f);
    ifp_op_e o;
    ifp_op_e r;
    o = OP_NOP;
    r = dec_f(w);
    if (ok && !pend) begin
      // first words of moves wait for their literal; lone second words do nothing
      if (!(r inside {OP_SECOND, OP_FFMOVE, OP_PTRLOAD})) o = r; // RULE_13
    end else if (ok && r == OP_SECOND) begin
      // second word in sequence: its literal is consumed by the first word
      if (dec_f(f) inside {OP_FFMOVE, OP_PTRLOAD}) o = dec_f(f); // RULE_13
    end
    return o;
  endfunction

  // data address from an 8-bit file field, access bank or selected bank
  function automatic logic [DADDR_W-1:0] fadr_f(input logic [WORD_W-1:0] w, input logic [3:0] bank);
    logic [3:0] b;
    if (w[ACC_BIT]) b = bank;
    else if (w[7:0] >= ACC_SPLIT) b = BANK_SFR;
    else b = BANK_GPR;
    return {b, w[7:0]};
  endfunction

  // ************************************************************
  // declarations
  // ************************************************************
  logic              rst_meta_q;
  logic              rst_n_q;
  ifp_phase_e        phase;
  logic [3:0]        phase_oh;
  logic [PC_W-1:0]   pc_q;
  logic [PC_W-1:0]   fetch_addr_q;
  logic [WORD_W-1:0] fetch_q;
  logic              fetch_ok_q;
  logic [WORD_W-1:0] ir_q;
  logic              ir_ok_q;
  logic              pend_q;
  logic [WORD_W-1:0] first_q;
  logic [BYTE_W-1:0] working_register_q;
  logic [BYTE_W-1:0] opnd_q;
  logic [PC_W-1:0]   table_byte_pointer_q;
  logic [BYTE_W-1:0] table_data_latch_q;
  logic              pmem_rd_q;
  logic              tbl_rd_q;
  ifp_dmem_s         dmem_q;
  ifp_ret_s          ret_q;
  ifp_ptr_s          ptr_q;
  ifp_op_e           xop;
  ifp_op_e           nxop;
  logic              nx_pend;
  logic [BYTE_W-1:0] sum;
  logic              to_pcl;
  logic              redirect;
  logic              discard;
  logic [PC_W-1:0]   target;
  logic [BYTE_W-1:0] rd_data;

  // ************************************************************
  // reset release
  // ************************************************************
  // two stages so every flop leaves reset on the same edge
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  ifp_phase_gen u_phase (
    .clk_i      (CLK_I),
    .rst_ni     (rst_n_q),
    .phase_o    (phase),
    .phase_oh_o (phase_oh)
  );

  // ************************************************************
  // execute decode
  // ************************************************************
  // current latch, and the word that enters the latch at the next phase_one
  assign xop     = xop_f(ir_ok_q, pend_q, ir_q, first_q);
  assign nx_pend = ir_ok_q && !pend_q && (dec_f(ir_q) inside {OP_GOTO, OP_CALL, OP_FFMOVE, OP_PTRLOAD});
  assign nxop    = xop_f(fetch_ok_q, nx_pend, fetch_q, ir_q);

  // alu result and flow decisions
  assign sum    = opnd_q + working_register_q;
  assign to_pcl = (xop == OP_ADD_WORKING_TO_FILE) && ir_q[DST_BIT] && (fadr_f(ir_q, BANK_I) == ADDR_CNT_LOW);
  assign redirect = (xop inside {OP_GOTO, OP_CALL, OP_BRA, OP_RETURN_WITH_LITERAL}) || to_pcl;
  // jumps and calls discard their own second word instead of a fetched one
  assign discard = (xop inside {OP_BRA, OP_RETURN_WITH_LITERAL}) || to_pcl ||
                   ((xop == OP_TEST_SKIP_IF_ZERO) && (opnd_q == 8'h00));  // RULE_04

  // target of a change of flow
  always_comb begin
    target = pc_q;
    unique case (xop)
      OP_GOTO, OP_CALL: target = {PMEM_DATA_I[11:0], ir_q[7:0], 1'b0};            // RULE_09
      OP_BRA:   target = fetch_addr_q + {{9{ir_q[10]}}, ir_q[10:0], 1'b0};        // RULE_10
      OP_RETURN_WITH_LITERAL: target = {RET_ADDR_I[PC_W-1:1], 1'b0};                            // RULE_16
      default:  if (to_pcl) target = {fetch_addr_q[PC_W-1:8], sum[7:1], 1'b0};   // RULE_14 RULE_15
    endcase
  end

  // operand source: counter and table registers live here, the rest outside
  always_comb begin
    unique case (DMEM_O.addr)
      ADDR_CNT_LOW:   rd_data = fetch_addr_q[7:0];
      ADDR_TBL_LATCH: rd_data = table_data_latch_q;
      ADDR_TBL_PTR_L: rd_data = table_byte_pointer_q[7:0];
      ADDR_TBL_PTR_H: rd_data = table_byte_pointer_q[15:8];
      ADDR_TBL_PTR_U: rd_data = {3'h0, table_byte_pointer_q[20:16]};
      default:        rd_data = DMEM_RDATA_I;
    endcase
  end

  // ************************************************************
  // program counter and fetch
  // ************************************************************
  // counter steps in phase_one, redirects land at the end of phase_four
  always_ff @(posedge CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pc_q         <= PC_RESET;
      fetch_addr_q <= PC_RESET;
    end else if (phase == PH_ONE) begin
      fetch_addr_q <= pc_q;                        // RULE_07
      pc_q         <= pc_q + PC_STEP;              // RULE_02 RULE_08
    end else if (phase == PH_FOUR && redirect) begin
      pc_q <= target;                              // RULE_04
    end
  end

  // read strobe spans phases two to four of each fetch
  always_ff @(posedge CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pmem_rd_q <= 1'b0;
    end else if (phase == PH_ONE) begin
      pmem_rd_q <= 1'b1;
    end else if (phase == PH_FOUR) begin
      pmem_rd_q <= 1'b0;
    end
  end

  // prefetch register; a flushed or skipped word is marked dead here
  always_ff @(posedge CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fetch_q    <= '0;
      fetch_ok_q <= 1'b0;
    end else if (phase == PH_FOUR) begin
      fetch_q    <= PMEM_DATA_I;                   // RULE_02 RULE_03
      fetch_ok_q <= !discard;                      // RULE_04
    end
  end

  // ************************************************************
  // instruction latch
  // ************************************************************
  // the first word is kept so its second word can complete it
  always_ff @(posedge CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ir_q    <= '0;
      ir_ok_q <= 1'b0;
      pend_q  <= 1'b0;
      first_q <= '0;
    end else if (phase == PH_ONE) begin
      ir_q    <= fetch_q;                          // RULE_05
      ir_ok_q <= fetch_ok_q;                       // RULE_03
      pend_q  <= nx_pend;                          // RULE_13
      first_q <= ir_q;
    end
  end

  // ************************************************************
  // data memory access
  // ************************************************************
  // read strobe in phase_two, write strobe in phase_four
  always_ff @(posedge CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dmem_q <= '0;
    end else begin
      unique case (phase)
        PH_ONE: begin
          dmem_q.rd <= nxop inside {OP_ADD_WORKING_TO_FILE, OP_TEST_SKIP_IF_ZERO, OP_FFMOVE};          // RULE_06
          dmem_q.addr <= (nxop == OP_FFMOVE) ? ir_q[11:0] : fadr_f(fetch_q, BANK_I);
        end
        PH_TWO: begin
          dmem_q.rd <= 1'b0;
        end
        PH_THREE: begin
          if (xop == OP_FFMOVE) begin
            dmem_q.wr    <= 1'b1;                  // RULE_06
            dmem_q.addr  <= ir_q[11:0];            // RULE_12
            dmem_q.wdata <= opnd_q;
          end else if (xop == OP_ADD_WORKING_TO_FILE && ir_q[DST_BIT] && !to_pcl) begin
            dmem_q.wr    <= 1'b1;                  // RULE_06
            dmem_q.wdata <= sum;
          end
        end
        PH_FOUR: begin
          dmem_q.wr <= 1'b0;
        end
      endcase
    end
  end

  // operand captured at the end of phase_two
  always_ff @(posedge CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      opnd_q <= '0;
    end else if (phase == PH_TWO && dmem_q.rd) begin
      opnd_q <= rd_data;                           // RULE_06
    end
  end

  // ************************************************************
  // working register
  // ************************************************************
  always_ff @(posedge CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      working_register_q <= WORKING_REGISTER_RESET;
    end else if (phase == PH_FOUR) begin
      if (xop == OP_MOVLW) working_register_q <= ir_q[7:0];
      else if (xop == OP_RETURN_WITH_LITERAL) working_register_q <= ir_q[7:0];                 // RULE_16
      else if (xop == OP_ADD_WORKING_TO_FILE && !ir_q[DST_BIT]) working_register_q <= sum;
    end
  end

  // ************************************************************
  // return stack and pointer load requests
  // ************************************************************
  // one-cycle pulses after phase_four; the stack itself sits outside
  always_ff @(posedge CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ret_q <= '0;
      ptr_q <= '0;
    end else if (phase == PH_FOUR) begin
      ret_q.push  <= (xop == OP_CALL);
      ret_q.pop   <= (xop == OP_RETURN_WITH_LITERAL);            // RULE_16
      ret_q.addr  <= pc_q;                         // already past the second word
      ptr_q.load  <= (xop == OP_PTRLOAD);          // RULE_13
      ptr_q.index <= first_q[5:4];
      ptr_q.value <= {first_q[3:0], ir_q[7:0]};    // RULE_12
    end else begin
      ret_q.push <= 1'b0;
      ret_q.pop  <= 1'b0;
      ptr_q.load <= 1'b0;
    end
  end

  // ************************************************************
  // table read engine
  // ************************************************************
  // single byte per read; the strobe covers phase_two only
  always_ff @(posedge CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tbl_rd_q <= 1'b0;
    end else if (phase == PH_ONE) begin
      tbl_rd_q <= nxop inside {OP_TBLRD, OP_TBLRD_INC};             // RULE_17
    end else begin
      tbl_rd_q <= 1'b0;
    end
  end

  // pointer and latch also accept data writes to their own addresses
  always_ff @(posedge CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      table_byte_pointer_q <= '0;
      table_data_latch_q <= '0;
    end else if (phase == PH_TWO && tbl_rd_q) begin
      table_data_latch_q <= TBL_DATA_I;                                        // RULE_17
      if (xop == OP_TBLRD_INC) table_byte_pointer_q <= table_byte_pointer_q + {1'b0, PC_STEP[PC_W-1:1]};
    end else if (phase == PH_FOUR && dmem_q.wr) begin
      unique case (dmem_q.addr)
        ADDR_TBL_LATCH: table_data_latch_q <= dmem_q.wdata;
        ADDR_TBL_PTR_L: table_byte_pointer_q[7:0] <= dmem_q.wdata;
        ADDR_TBL_PTR_H: table_byte_pointer_q[15:8] <= dmem_q.wdata;
        ADDR_TBL_PTR_U: table_byte_pointer_q[20:16] <= dmem_q.wdata[4:0];
        default: ;
      endcase
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign PHASE_O      = phase_oh;
  assign PMEM_ADDR_O  = fetch_addr_q;
  assign PMEM_RD_O    = pmem_rd_q;
  assign DMEM_O       = dmem_q;
  assign TBL_ADDR_O   = table_byte_pointer_q;
  assign TBL_RD_O     = tbl_rd_q;
  assign RET_O        = ret_q;
  assign PTR_LOAD_O   = ptr_q;
  assign EXEC_WORD_O  = ir_q;
  assign EXEC_VALID_O = ir_ok_q;
  assign WORKING_REGISTER_O       = working_register_q;

endmodule

// File: ifp_fetch_core_sva.sv
// checker for the fetch pipeline top, sees its ports only
// assumes the bind below and the core clock as sampling clock
`timescale 1ns/1ps

module ifp_fetch_core_sva
  import ifp_pkg::*;
(
  input wire logic              CLK_I,
  input wire logic              NRST_I,
  input wire logic [3:0]        PHASE_O,
  input wire logic [PC_W-1:0]   PMEM_ADDR_O,
  input wire logic              PMEM_RD_O,
  input wire ifp_dmem_s         DMEM_O,
  input wire logic              TBL_RD_O,
  input wire ifp_ret_s          RET_O,
  input wire logic [WORD_W-1:0] EXEC_WORD_O
);
  // ****
  // properties
  // ****
  // one clock domain, so clocking and disable are given once
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  a_phase_onehot: assert property ($onehot(PHASE_O))
    else $error("phase not one-hot");
  a_phase_order: assert property (PHASE_O == 4'h2 |=> PHASE_O == 4'h4 ##1 PHASE_O == 4'h8
    ##1 PHASE_O == 4'h1 ##1 PHASE_O == 4'h2) else $error("phase order broken");
  a_addr_even: assert property (PMEM_ADDR_O[0] == 1'b0)
    else $error("odd fetch address");
  a_addr_moves: assert property ($changed(PMEM_ADDR_O) |-> $past(PHASE_O) == 4'h1)
    else $error("fetch address moved outside phase one");
  a_fetch_window: assert property (PMEM_RD_O == (PHASE_O != 4'h1))
    else $error("fetch strobe outside phases two to four");
  a_operand_read: assert property (DMEM_O.rd |-> PHASE_O == 4'h2)
    else $error("operand read outside phase two");
  a_result_write: assert property (DMEM_O.wr |-> PHASE_O == 4'h8)
    else $error("write-back outside phase four");
  a_table_read: assert property (TBL_RD_O |-> PHASE_O == 4'h2)
    else $error("table read outside phase two");
  a_latch_load: assert property ($changed(EXEC_WORD_O) |-> $past(PHASE_O) == 4'h1)
    else $error("latch changed outside phase one");
  a_pop_pulse: assert property (RET_O.pop |-> PHASE_O == 4'h1 ##1 !RET_O.pop)
    else $error("return pop not a single pulse");
endmodule

bind ifp_fetch_core ifp_fetch_core_sva ifp_fetch_core_sva_inst (
  .CLK_I(CLK_I), .NRST_I(NRST_I), .PHASE_O(PHASE_O), .PMEM_ADDR_O(PMEM_ADDR_O),
  .PMEM_RD_O(PMEM_RD_O), .DMEM_O(DMEM_O), .TBL_RD_O(TBL_RD_O), .RET_O(RET_O),
  .EXEC_WORD_O(EXEC_WORD_O));

// File: ifp_pmem_model.sv
// behavioural word-wide program memory facing the fetch pipeline
// assumes the bench fills mem before it releases reset
`timescale 1ns/1ps

module ifp_pmem_model
  import ifp_pkg::*;
(
  input  wire logic [PC_W-1:0]   addr_i,
  input  wire logic              rd_i,
  output logic      [WORD_W-1:0] data_o
);
  // ****
  // storage
  // ****
  logic [WORD_W-1:0] mem [64];

  // byte bit dropped; an idle bus shows the inverse so stale words never pass
  assign data_o = rd_i ? mem[addr_i[6:1]] : ~mem[addr_i[6:1]];
endmodule

// File: ifp_fetch_core_bench.sv
// self-checking bench for the fetch pipeline top
// assumes the memory model and the bound checker are compiled first
`timescale 1ns/1ps

module ifp_fetch_core_bench
  import ifp_pkg::*;
;
  // ****
  // signals
  // ****
  localparam time DLY = 5ns;
  logic              clk;
  logic              rst_n;
  logic [WORD_W-1:0] pmem_data;
  logic [BYTE_W-1:0] dmem_rdata;
  logic [3:0]        bank;
  logic [PC_W-1:0]   ret_addr;
  logic [BYTE_W-1:0] tbl_data;
  logic [3:0]        phase;
  logic [PC_W-1:0]   pmem_addr;
  logic              pmem_rd;
  ifp_dmem_s         dmem;
  logic              tbl_rd;
  logic [PC_W-1:0]   tbl_addr;
  ifp_ret_s          ret;
  ifp_ptr_s          ptr;
  ifp_ptr_s          ptr_seen;
  logic [WORD_W-1:0] exec_word;
  logic              exec_valid;
  logic [BYTE_W-1:0] working_register;
  int                errors;
  int                samples_checked;
  int                cyc;
  int                pops;
  logic [15:0]       ran [$];
  int                ran_t [$];
  logic [19:0]       wr_log [$];

  // ****
  // instances
  // ****
  ifp_fetch_core ifp_fetch_core_inst (
    .CLK_I(clk), .NRST_I(rst_n), .PMEM_DATA_I(pmem_data), .DMEM_RDATA_I(dmem_rdata),
    .BANK_I(bank), .RET_ADDR_I(ret_addr), .TBL_DATA_I(tbl_data), .PHASE_O(phase),
    .PMEM_ADDR_O(pmem_addr), .PMEM_RD_O(pmem_rd), .DMEM_O(dmem), .TBL_ADDR_O(tbl_addr),
    .TBL_RD_O(tbl_rd), .RET_O(ret), .PTR_LOAD_O(ptr), .EXEC_WORD_O(exec_word),
    .EXEC_VALID_O(exec_valid), .WORKING_REGISTER_O(working_register));
  ifp_pmem_model ifp_pmem_model_inst (.addr_i(pmem_addr), .rd_i(pmem_rd), .data_o(pmem_data));

  // ****
  // helpers
  // ****
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // log executed words with their cycle, write-backs and return pops
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (exec_valid === 1'b1 && phase === 4'h2) begin
      ran.push_back(exec_word);
      ran_t.push_back(cyc);
    end
    if (dmem.wr === 1'b1) wr_log.push_back({dmem.addr, dmem.wdata});
    if (ret.pop === 1'b1) pops++;
    if (ptr.load === 1'b1) ptr_seen <= ptr;
  end

  // cycle at which a word executed, -1 when it never did
  function automatic int t_of(logic [15:0] w);
    foreach (ran[i]) if (ran[i] === w) return ran_t[i];
    return -1;
  endfunction

  task automatic chk(logic [31:0] got, logic [31:0] exp, string msg);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask

  // bounded wait for the working register, then compare it
  task automatic wait_w(logic [7:0] v, string msg);
    int n;
    n = 0;
    while (working_register !== v && n < 200) begin
      @(posedge clk);
      #DLY;
      n++;
    end
    chk({24'h0, working_register}, {24'h0, v}, msg);
  endtask

  // fill memory, then reset; logs are cleared so each run is judged alone
  task automatic load(logic [15:0] p [8]);
    for (int i = 0; i < 64; i++) ifp_pmem_model_inst.mem[i] = (i < 8) ? p[i] : 16'h0000;
    @(posedge clk);
    #DLY;
    rst_n = 1'b0;
    repeat (8) @(posedge clk);
    chk({28'h0, phase}, 32'h1, "phase in reset");
    #DLY;
    ran.delete();
    ran_t.delete();
    wr_log.delete();
    pops = 0;
    rst_n = 1'b1;
  endtask

  // ****
  // scenarios
  // ****
  task automatic t_seq();
    load('{16'h0e55, 16'h0e12, 16'h0e34, 16'h0e56, 16'h0, 16'h0, 16'h0, 16'h0});
    wait_w(8'h56, "sequence end");
    chk(t_of(16'h0e56) - t_of(16'h0e55), 12, "pipeline rate");
    chk(pmem_addr, 32'h8, "fetch step");
    $display("t_seq done");
  endtask

  task automatic t_jump(logic [15:0] w0, logic [15:0] w1, int tgt);
    logic [15:0] p [8];
    p = '{w0, w1, 16'h0e12, 16'h0e13, 16'h0e14, 16'h0e15, 16'h0e16, 16'h0e17};
    p[tgt] = 16'h0e22;
    load(p);
    wait_w(8'h22, "flow target");
    chk(t_of(16'h0e11), -1, "flushed word ran");
    chk(t_of(16'h0e12), -1, "flushed word ran");
    chk(t_of(16'h0e22) - t_of(w0), 8, "flow cost");
    $display("t_jump done");
  endtask

  task automatic t_skip(logic [7:0] v);
    logic [31:0] hit;
    dmem_rdata = v;
    load('{16'h6600, 16'hc123, 16'hf456, 16'h0e22, 16'h0, 16'h0, 16'h0, 16'h0});
    wait_w(8'h22, "after move");
    hit = 32'hffffffff;
    foreach (wr_log[i]) if (wr_log[i][19:8] === 12'h456) hit = {24'h0, wr_log[i][7:0]};
    chk(hit, (v == 8'h00) ? 32'hffffffff : {24'h0, v}, "move write-back");
    $display("t_skip done");
  endtask

  task automatic t_cjump();
    ret_addr = 21'h00000e;
    // table offset kept even so the target stays aligned
    load('{16'h0e04, 16'h26f9, 16'h0c11, 16'h0c22, 16'h0c33, 16'h0, 16'h0, 16'h0e55});
    wait_w(8'h33, "table value");
    chk(t_of(16'h0c11), -1, "computed jump missed");
    chk(t_of(16'h0c22), -1, "computed jump missed");
    wait_w(8'h55, "return target");
    chk(pops, 1, "return pops");
    $display("t_cjump done");
  endtask

  // table read with increment, then latch and pointer read back through the adder
  task automatic t_table();
    tbl_data = 8'h3c;
    load('{16'h0009, 16'h24f5, 16'h24f6, 16'hee12, 16'hf034, 16'h0e77, 16'h0, 16'h0});
    wait_w(8'h3c, "table byte");
    wait_w(8'h3d, "table pointer step");
    chk(tbl_addr, 32'h1, "table address");
    wait_w(8'h77, "after pointer load");
    chk(ptr_seen, 32'h5234, "pointer load");
    $display("t_table done");
  endtask

  // ****
  // main
  // ****
  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // tests take a few hundred cycles; ten thousand means a hang
  initial begin
    #500us;
    errors++;
    $display("FAIL %0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    errors = 0;
    samples_checked = 0;
    cyc = 0;
    pops = 0;
    rst_n = 1'b0;
    dmem_rdata = 8'h00;
    bank = 4'h0;
    ret_addr = 21'h000000;
    tbl_data = 8'h00;
    t_seq();
    t_jump(16'hef05, 16'hf000, 5);
    t_jump(16'hd002, 16'h0e11, 3);
    t_skip(8'h00);
    t_skip(8'h5a);
    t_cjump();
    t_table();
    end_sim();
  end
endmodule
